// >>> pic_ctrl.sv
// prioritized interrupt control unit: flags, masks, vector selection, entry sequencing
`timescale 1ns/1ns
`default_nettype none

module pic_ctrl
   import pic_pkg::*;
#(
   parameter int VEC_W = 14,
   parameter int SETTLE_NS = SETTLE_NS_DEF
) (
   input wire logic MCLK, // system clock
   input wire logic RST_N, // synchronous reset, active low
   input wire logic [9:0] RAM_ADDR, // data memory address
   input wire logic RAM_WE, // write strobe
   input wire logic [3:0] RAM_WMASK, // bits written, one hot for bit operations
   input wire logic [3:0] RAM_WDATA, // write data
   input wire logic RAM_RE, // read strobe
   output logic [3:0] RAM_RDATA, // read data, one cycle after the strobe
   output logic RAM_SEL, // address belongs to this unit
   input wire logic RETURN_FROM_SERVICE_OP_EXEC, // return-from-service executed
   input wire logic STOP_MODE, // core is in stop mode
   input wire logic [3:0] RESUME_PIN_N, // resume pins, falling edge active
   input wire logic EXT_REQUEST_0_N, // external request 0 pin
   input wire logic EXT_REQUEST_1, // external request 1 pin
   input wire logic CNT_A_OVF, // counter A overflow pulse
   input wire logic CNT_B_OVF, // counter B overflow pulse
   input wire logic CNT_C_OVF, // counter C overflow pulse
   input wire logic CNT_D_OVF, // counter D overflow pulse
   input wire logic CNT_D_CAPT, // counter D capture edge pulse
   input wire logic SER_DONE, // serial transfer complete pulse
   input wire logic SER_HALT, // serial transfer halted pulse
   input wire logic CONV_DONE, // conversion complete pulse
   output logic INT_FINISH, // entry cycle one: finish instruction
   output logic STACK_PUSH, // entry cycles two and three: push state
   output logic PC_LOAD, // entry cycle three: load vector
   output logic [VEC_W-1:0] VECTOR, // selected vector address
   output logic WAKE_ACTIVE // stop mode left after settling
);

   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   if (VEC_W < 4 || VEC_W > 16 || SETTLE_CYC < 1) begin : g_bad_param
      $error("pic_ctrl: unsupported parameter values");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pic_state_t state_r, state_nxt;
   logic gate_r, gate_nxt;
   logic [NSRC-1:0] pend_r, pend_nxt, blk_r, blk_nxt, ev;
   logic [1:0] edge_sel_r, edge_sel_nxt;
   logic [3:0] res_prev_r, rd_nxt;
   logic ext0_prev_r, ext1_prev_r, armed_r;
   logic [31:0] settle_r, settle_nxt;
   logic [VEC_W-1:0] vec_w;
   logic [NGRP-1:0] greq;
   logic [2:0] grp_w;

   function automatic logic [2:0] pic_top_group(input logic [NGRP-1:0] g);
      logic [2:0] idx;
      idx = 3'h0;
      for (int k = NGRP - 1; k >= 0; k--) begin
         if (g[k]) begin
            idx = 3'(k);
         end
      end
      return idx;
   endfunction

   // ----------------------------------------------------------------
   // edge detection and source events
   // ----------------------------------------------------------------
   wire logic res_fall = armed_r && |(res_prev_r & ~RESUME_PIN_N);
   wire logic ext0_fall = armed_r && ext0_prev_r && !EXT_REQUEST_0_N;
   wire logic ext1_rise = armed_r && !ext1_prev_r && EXT_REQUEST_1;
   wire logic ext1_fall = armed_r && ext1_prev_r && !EXT_REQUEST_1;
   wire logic ext1_evt = (edge_sel_r[0] && ext1_fall) || (edge_sel_r[1] && ext1_rise);

   assign ev[SRC_RESUME] = res_fall && !STOP_MODE;
   assign ev[SRC_EXT0] = ext0_fall;
   assign ev[SRC_EXT1] = ext1_evt;
   assign ev[SRC_CNTA] = CNT_A_OVF;
   assign ev[SRC_CNTB] = CNT_B_OVF;
   assign ev[SRC_CNTC] = CNT_C_OVF;
   assign ev[SRC_CNTD] = CNT_D_OVF || CNT_D_CAPT;
   assign ev[SRC_SER] = SER_DONE || SER_HALT;
   assign ev[SRC_CONV] = CONV_DONE;

   // ----------------------------------------------------------------
   // flag and block bit writes
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NSRC; i++) begin : g_src
      wire logic hit = RAM_WE && (RAM_ADDR == SRC_ADDR[i]);
      wire logic clr = hit && RAM_WMASK[SRC_BIT[i]] && !RAM_WDATA[SRC_BIT[i]];
      wire logic bw = hit && RAM_WMASK[SRC_BIT[i] + 2'h1];
      // written ones are ignored, and an event wins over a clear
      assign pend_nxt[i] = ev[i] || (pend_r[i] && !clr);
      assign blk_nxt[i] = bw ? RAM_WDATA[SRC_BIT[i] + 2'h1] : blk_r[i];
   end

   wire logic gate_wr = RAM_WE && (RAM_ADDR == ADR_GATE) && RAM_WMASK[GATE_BIT];
   wire logic edge_wr = RAM_WE && (RAM_ADDR == ADR_EDGE);

   always_comb begin
      edge_sel_nxt = edge_sel_r;
      for (int b = 0; b < 2; b++) begin
         if (edge_wr && RAM_WMASK[b]) begin
            edge_sel_nxt[b] = RAM_WDATA[b];
         end
      end
   end

   // acceptance clears the gate in cycle two, return-from-service sets it
   assign gate_nxt = (state_r == ST_SAVE) ? 1'b0 :
                     RETURN_FROM_SERVICE_OP_EXEC ? 1'b1 :
                     gate_wr ? RAM_WDATA[GATE_BIT] : gate_r;

   // ----------------------------------------------------------------
   // priority and vector
   // ----------------------------------------------------------------
   wire logic [NSRC-1:0] req = pend_r & ~blk_r;
   assign greq = {req[SRC_SER] || req[SRC_CONV], req[SRC_CNTC],
                  req[SRC_CNTB] || req[SRC_CNTD], req[SRC_CNTA],
                  req[SRC_EXT1], req[SRC_EXT0], req[SRC_RESUME]};
   assign grp_w = pic_top_group(greq);
   assign vec_w = VEC_W'(VEC_RESET + VEC_STEP * (14'(grp_w) + 14'h1));
   wire logic start_w = (state_r == ST_IDLE) && gate_r && (greq != '0);

   // ----------------------------------------------------------------
   // entry sequence
   // ----------------------------------------------------------------
   always_comb begin
      case (state_r)
         ST_IDLE: state_nxt = start_w ? ST_FIN : ST_IDLE;
         ST_FIN: state_nxt = ST_SAVE;
         ST_SAVE: state_nxt = ST_JUMP;
         ST_JUMP: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   assign INT_FINISH = (state_r == ST_FIN);
   assign STACK_PUSH = (state_r == ST_SAVE) || (state_r == ST_JUMP);
   assign PC_LOAD = (state_r == ST_JUMP);

   // ----------------------------------------------------------------
   // stop mode wake timer
   // ----------------------------------------------------------------
   wire logic settle_go = STOP_MODE && res_fall && (settle_r == 32'h0);
   assign settle_nxt = settle_go ? 32'(SETTLE_CYC) :
                       (settle_r != 32'h0) ? settle_r - 32'h1 : settle_r;

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   always_comb begin
      rd_nxt = 4'h0;
      if (RAM_ADDR == ADR_GATE) begin
         rd_nxt[GATE_BIT] = gate_r;
      end
      for (int i = 0; i < NSRC; i++) begin
         if (RAM_ADDR == SRC_ADDR[i]) begin
            rd_nxt[SRC_BIT[i]] = pend_r[i];
            rd_nxt[SRC_BIT[i] + 2'h1] = blk_r[i];
         end
      end
   end

   assign RAM_SEL = (RAM_ADDR == ADR_GATE) || (RAM_ADDR == ADR_EXT) || (RAM_ADDR == ADR_CNTAB) ||
                    (RAM_ADDR == ADR_CNTC) || (RAM_ADDR == ADR_EDGE) || (RAM_ADDR == ADR_CNTD) ||
                    (RAM_ADDR == ADR_SER);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         state_r <= ST_IDLE;
         gate_r <= GATE_RST;
         pend_r <= PEND_RST;
         blk_r <= BLK_RST;
         edge_sel_r <= EDGE_RST;
         armed_r <= 1'b0;
         settle_r <= 32'h0;
         VECTOR <= VEC_W'(VEC_RESET);
         RAM_RDATA <= 4'h0;
         WAKE_ACTIVE <= 1'b0;
      end else begin
         state_r <= state_nxt;
         gate_r <= gate_nxt;
         pend_r <= pend_nxt;
         blk_r <= blk_nxt;
         edge_sel_r <= edge_sel_nxt;
         armed_r <= 1'b1;
         settle_r <= settle_nxt;
         if (start_w) begin
            VECTOR <= vec_w;
         end
         if (RAM_RE) begin
            RAM_RDATA <= rd_nxt;
         end
         WAKE_ACTIVE <= (settle_r == 32'h1);
      end
   end

   always_ff @(posedge MCLK) begin
      res_prev_r <= RESUME_PIN_N;
      ext0_prev_r <= EXT_REQUEST_0_N;
      ext1_prev_r <= EXT_REQUEST_1;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   a_entry_order: assert property (INT_FINISH |=> STACK_PUSH && !PC_LOAD ##1 STACK_PUSH && PC_LOAD)
      else $error("entry sequence out of order");
   a_gate_drop: assert property (INT_FINISH ##1 STACK_PUSH |=> !gate_r)
      else $error("gate not cleared in cycle two");
   a_vector_load: assert property (start_w |-> ##3 (PC_LOAD && VECTOR == $past(vec_w, 3)))
      else $error("vector not loaded in cycle three");
   a_start_cond: assert property (INT_FINISH |-> $past(gate_r) && $past(greq) != '0)
      else $error("service started without gate or request");
   a_top_prio: assert property (start_w && greq[0] |-> vec_w == VEC_W'(VEC_RESET + VEC_STEP))
      else $error("resume request not chosen first");
   a_shared_vec: assert property (start_w && greq[3:0] == '0 && req[SRC_CNTD] |-> vec_w == VEC_W'(14'h000A))
      else $error("counter D vector wrong");
   a_no_sw_set: assert property ((pend_r & ~$past(pend_r) & ~$past(ev)) == '0)
      else $error("pending flag set without event");
   a_ext0_edge: assert property (ext0_fall |=> pend_r[SRC_EXT0])
      else $error("external 0 edge lost");
   a_ext1_none: assert property (edge_sel_r == EDGE_NONE |-> !ev[SRC_EXT1])
      else $error("edge detected with selection off");
   a_stop_quiet: assert property (STOP_MODE && res_fall && !pend_r[SRC_RESUME] |=> !pend_r[SRC_RESUME])
      else $error("resume flag set in stop mode");
   a_reset_vals: assert property (disable iff (1'b0) !RST_N |=> !gate_r && pend_r == PEND_RST && blk_r == BLK_RST)
      else $error("reset values wrong");
   a_gate_return_from_service_op: assert property (RETURN_FROM_SERVICE_OP_EXEC && state_r != ST_SAVE |=> gate_r)
      else $error("gate not set by return from service");
   a_gate_hold: assert property (!gate_r |=> !INT_FINISH)
      else $error("service started with gate closed");
   a_req_starts: assert property (state_r == ST_IDLE && gate_r && req != '0 |=> INT_FINISH)
      else $error("unblocked request not taken");
   a_masked_quiet: assert property (req == '0 |=> !INT_FINISH)
      else $error("service started with every request blocked");
   a_res_edge: assert property (res_fall && !STOP_MODE |=> pend_r[SRC_RESUME])
      else $error("resume edge lost");
   a_ext1_fall: assert property (edge_sel_r[0] && ext1_fall |=> pend_r[SRC_EXT1])
      else $error("external 1 falling edge lost");
   a_ext1_rise: assert property (edge_sel_r[1] && ext1_rise |=> pend_r[SRC_EXT1])
      else $error("external 1 rising edge lost");
   a_cnt_a: assert property (CNT_A_OVF |=> pend_r[SRC_CNTA])
      else $error("counter A event lost");
   a_cnt_d: assert property (CNT_D_OVF || CNT_D_CAPT |=> pend_r[SRC_CNTD])
      else $error("counter D event lost");
   a_ser_flag: assert property (SER_DONE || SER_HALT |=> pend_r[SRC_SER])
      else $error("serial event lost");
   a_conv_flag: assert property (CONV_DONE |=> pend_r[SRC_CONV])
      else $error("converter event lost");
   a_entry_events: assert property (state_r != ST_IDLE |=> (pend_r & $past(ev)) == $past(ev))
      else $error("event lost during entry sequence");
   a_edge_wo: assert property (RAM_RE && RAM_ADDR == ADR_EDGE |=> RAM_RDATA == 4'h0)
      else $error("edge select readable");
   a_rdata_hold: assert property (!RAM_RE |=> $stable(RAM_RDATA))
      else $error("read data changed without strobe");

   c_entry: cover property (start_w ##3 PC_LOAD);
   c_shared: cover property (start_w && greq[6]);
   c_return_from_service_op: cover property (PC_LOAD ##[1:50] RETURN_FROM_SERVICE_OP_EXEC);
   c_wake: cover property (settle_go);
   c_both: cover property (edge_sel_r == EDGE_BOTH && ev[SRC_EXT1]);

endmodule

`default_nettype wire

// >>> pic_pkg.sv
// constants, register map and types of the prioritized interrupt control unit
package pic_pkg;

   // ----------------------------------------------------------------
   // sources, by pending flag index; CNTD shares the priority of CNTB, above CNTC
   // ----------------------------------------------------------------
   localparam int NSRC = 9;
   localparam int SRC_RESUME = 0;
   localparam int SRC_EXT0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_CNTA = 3;
   localparam int SRC_CNTB = 4;
   localparam int SRC_CNTC = 5;
   localparam int SRC_CNTD = 6;
   localparam int SRC_SER = 7;
   localparam int SRC_CONV = 8;
   localparam int NGRP = 7;

   // ----------------------------------------------------------------
   // data memory map
   // ----------------------------------------------------------------
   localparam logic [9:0] ADR_GATE = 10'h000;
   localparam logic [9:0] ADR_EXT = 10'h001;
   localparam logic [9:0] ADR_CNTAB = 10'h002;
   localparam logic [9:0] ADR_CNTC = 10'h003;
   localparam logic [9:0] ADR_EDGE = 10'h006;
   localparam logic [9:0] ADR_CNTD = 10'h022;
   localparam logic [9:0] ADR_SER = 10'h023;
   // pending flag bit of each source; its block bit sits one above
   localparam logic [9:0] SRC_ADDR [NSRC] = '{ADR_GATE, ADR_EXT, ADR_EXT, ADR_CNTAB, ADR_CNTAB,
                                             ADR_CNTC, ADR_CNTD, ADR_SER, ADR_CNTC};
   localparam logic [1:0] SRC_BIT [NSRC] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2};
   localparam logic [1:0] GATE_BIT = 2'h0;

   // ----------------------------------------------------------------
   // reset values, encodings, vectors, timing
   // ----------------------------------------------------------------
   localparam logic GATE_RST = 1'b0;
   localparam logic [NSRC-1:0] PEND_RST = 9'h000;
   localparam logic [NSRC-1:0] BLK_RST = 9'h1FF;
   localparam logic [1:0] EDGE_RST = 2'h0;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [13:0] VEC_RESET = 14'h0000;
   localparam logic [13:0] VEC_STEP = 14'h0002;
   localparam int CLK_NS = 10;
   localparam int SETTLE_NS_DEF = 10000;

   typedef enum logic [1:0] {ST_IDLE, ST_FIN, ST_SAVE, ST_JUMP} pic_state_t;

endpackage

// >>> pic_core_model.sv
// processor core model: follows the entry sequence and returns from service
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
   input wire logic clk, // system clock
   input wire logic int_finish, // entry cycle one
   input wire logic stack_push, // entry cycles two and three
   input wire logic pc_load, // entry cycle three
   input wire logic [13:0] vector, // selected vector
   input wire logic [7:0] handler_len, // cycles spent in the handler
   output logic return_from_service_op = 1'b0, // return-from-service pulse
   output logic [13:0] pc = 14'h0000, // program counter after the jump
   output logic [3:0] pushes = 4'h0, // pushes of the last entry
   output logic [7:0] loads = 8'h00 // vectors taken so far
);
   int wait_c = 0;
   // a new entry restarts the handler, so a stale return is dropped
   always @(posedge clk) begin
      return_from_service_op <= 1'b0;
      if (int_finish === 1'b1) pushes <= 4'h0;
      if (stack_push === 1'b1) pushes <= pushes + 4'h1;
      if (pc_load === 1'b1) begin
         pc <= vector;
         loads <= loads + 8'h01;
         wait_c <= handler_len;
      end else if (wait_c > 0) begin
         wait_c <= wait_c - 1;
         return_from_service_op <= (wait_c == 1);
      end
   end
endmodule
`default_nettype wire

// >>> prioritized_interrupt_control_tb.sv
// testbench of the prioritized interrupt control unit
`timescale 1ns/1ns
`default_nettype none
module prioritized_interrupt_control_tb;
   import pic_pkg::*;
   typedef struct {int ev; int src; logic [13:0] vec;} pic_row_t;
   localparam int SETTLE = 50;
   logic clk = 1'b0, rst_n = 1'b0, ram_we = 1'b0, ram_re = 1'b0, stop = 1'b0, ext0_n = 1'b1, ext1 = 1'b1;
   logic [9:0] ram_addr = 10'h000;
   logic [3:0] ram_wmask = 4'h0, ram_wdata = 4'h0, resume_n = 4'hF, ram_rdata, d, pushes;
   logic [7:0] pulse = 8'h00, loads;
   logic ram_sel, return_from_service_op, int_fin, push, pc_load, wake;
   logic [13:0] vector, pc;
   int miscompares = 0, n_compared = 0, k;
   pic_row_t rows [11] = '{'{0, 0, 14'h0002}, '{1, 1, 14'h0004}, '{2, 2, 14'h0006}, '{3, 3, 14'h0008},
      '{4, 4, 14'h000A}, '{5, 5, 14'h000C}, '{6, 6, 14'h000A}, '{7, 6, 14'h000A}, '{8, 7, 14'h000E},
      '{9, 7, 14'h000E}, '{10, 8, 14'h000E}};
   logic [9:0] radr [6] = '{ADR_GATE, ADR_EXT, ADR_CNTAB, ADR_CNTC, ADR_CNTD, ADR_SER};
   logic [3:0] rexp [6] = '{4'h8, 4'hA, 4'hA, 4'hA, 4'h8, 4'h8};

   pic_ctrl #(.VEC_W(14), .SETTLE_NS(SETTLE * CLK_NS)) uut (.MCLK(clk), .RST_N(rst_n), .RAM_ADDR(ram_addr),
      .RAM_WE(ram_we), .RAM_WMASK(ram_wmask), .RAM_WDATA(ram_wdata), .RAM_RE(ram_re), .RAM_RDATA(ram_rdata),
      .RAM_SEL(ram_sel), .RETURN_FROM_SERVICE_OP_EXEC(return_from_service_op), .STOP_MODE(stop), .RESUME_PIN_N(resume_n),
      .EXT_REQUEST_0_N(ext0_n), .EXT_REQUEST_1(ext1), .CNT_A_OVF(pulse[0]), .CNT_B_OVF(pulse[1]),
      .CNT_C_OVF(pulse[2]), .CNT_D_OVF(pulse[3]), .CNT_D_CAPT(pulse[4]), .SER_DONE(pulse[5]),
      .SER_HALT(pulse[6]), .CONV_DONE(pulse[7]), .INT_FINISH(int_fin), .STACK_PUSH(push),
      .PC_LOAD(pc_load), .VECTOR(vector), .WAKE_ACTIVE(wake));
   pic_core_model core (.clk(clk), .int_finish(int_fin), .stack_push(push), .pc_load(pc_load),
      .vector(vector), .handler_len(8'h1E), .return_from_service_op(return_from_service_op), .pc(pc), .pushes(pushes), .loads(loads));

   initial begin
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // bus cycles, events and checks
   // ----------------------------------------------------------------
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(logic [13:0] got, logic [13:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_hi(ref logic s, input int lim, output int n);
      for (n = 0; n < lim && s !== 1'b1; n++) cyc(1);
      if (n == lim) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic wr(logic [9:0] a, logic [3:0] m, logic [3:0] v);
      ram_addr = a;
      ram_wmask = m;
      ram_wdata = v;
      ram_we = 1'b1;
      cyc(1);
      ram_we = 1'b0;
      // idle cycle: a following access never rewrites the strobe in one step
      cyc(1);
   endtask
   task automatic rd(logic [9:0] a);
      ram_addr = a;
      ram_re = 1'b1;
      cyc(1);
      ram_re = 1'b0;
      d = ram_rdata;
      cyc(1);
   endtask
   task automatic fire(int ev);
      if (ev == 0) resume_n = 4'h7;
      else if (ev == 1) ext0_n = 1'b0;
      else if (ev == 2) ext1 = 1'b0;
      else pulse[ev-3] = 1'b1;
      cyc(1);
      resume_n = 4'hF;
      ext0_n = 1'b1;
      ext1 = 1'b1;
      pulse = 8'h00;
      cyc(1);
   endtask
   // enable service, follow the entry, then clear and block the source
   task automatic serve(int s, logic [13:0] v);
      int n;
      wr(ADR_GATE, 4'h1, 4'h1);
      wait_hi(pc_load, 20, n);
      chk(vector, v);
      cyc(1);
      chk(pc, v);
      chk(14'(pushes), 14'h0002);
      rd(ADR_GATE);
      chk(14'(d[0]), 14'h0000);
      rd(SRC_ADDR[s]);
      chk(14'(d[SRC_BIT[s]]), 14'h0001);
      wr(SRC_ADDR[s], 4'(1 << SRC_BIT[s]), 4'h0);
      wr(SRC_ADDR[s], 4'(2 << SRC_BIT[s]), 4'hF);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
      wr(ADR_EDGE, 4'h3, 4'(EDGE_FALL));
      foreach (rows[i]) begin
         wr(ADR_GATE, 4'h1, 4'h0);
         wr(SRC_ADDR[rows[i].src], 4'(2 << SRC_BIT[rows[i].src]), 4'h0);
         fire(rows[i].ev);
         cyc(2);
         chk(14'(loads), 14'(i));
         serve(rows[i].src, rows[i].vec);
         wait_hi(return_from_service_op, 40, k);
         cyc(1);
         rd(ADR_GATE);
         chk(14'(d[0]), 14'h0001);
      end
      wr(ADR_GATE, 4'h1, 4'h0);
      wr(ADR_EXT, 4'h2, 4'h0);
      wr(ADR_CNTC, 4'h2, 4'h0);
      fire(5);
      fire(1);
      fire(3);
      serve(SRC_EXT0, 14'h0004);
      serve(SRC_CNTC, 14'h000C);
      wait_hi(return_from_service_op, 40, k);
      cyc(3);
      chk(14'(loads), 14'd13);
      wr(ADR_CNTAB, 4'h2, 4'h0);
      serve(SRC_CNTA, 14'h0008);
      for (int c = 0; c < 4; c++) begin
         wr(ADR_EDGE, 4'h3, 4'(c));
         for (int e = 0; e < 2; e++) begin
            ext1 = ~ext1;
            cyc(2);
            rd(ADR_EXT);
            chk(14'(d[2]), 14'((c >> e) & 1));
            wr(ADR_EXT, 4'h4, 4'h0);
         end
      end
      rd(ADR_EDGE);
      chk(14'(d), 14'h0000);
      wr(ADR_CNTAB, 4'hF, 4'hF);
      rd(ADR_CNTAB);
      chk(14'(d), 14'h000A);
      stop = 1'b1;
      resume_n = 4'hE;
      wait_hi(wake, 100, k);
      chk(14'(k >= SETTLE - 2 && k <= SETTLE + 3), 14'h0001);
      stop = 1'b0;
      resume_n = 4'hF;
      rd(ADR_GATE);
      chk(14'(d[2]), 14'h0000);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
      chk(vector, VEC_RESET);
      for (int i = 0; i < 6; i++) begin
         rd(radr[i]);
         chk(14'({ram_sel, d}), 14'({1'b1, rexp[i]}));
      end
      rd(10'h004);
      chk(14'({ram_sel, d}), 14'h0000);
      conclude();
   end
endmodule
`default_nettype wire
